//--- verilog/hrp_cfg.svh
// timing, width and reset constants of the histogram ram processor
`ifndef HRP_CFG_SVH
`define HRP_CFG_SVH
`define HRP_DATA_W 24
`define HRP_ADDR_W 10
`define HRP_DEPTH 1024
`define HRP_LAST_ADDR 10'h3FF
`define HRP_PIPE_DEPTH 3
`define HRP_HIST_STEP 24'h000001
`define HRP_WORD_ZERO 24'h000000
`define HRP_ADDR_ZERO 10'h000
`define HRP_MODE_HIST 3'h0
`define HRP_MODE_HISTACC 3'h1
`define HRP_MODE_DELAYSUB 3'h2
`define HRP_MODE_LOOKUP 3'h3
`define HRP_MODE_BINACC 3'h4
`define HRP_MODE_DELAYMEM 3'h5
`define HRP_MODE_ASYNC24 3'h6
`define HRP_MODE_ASYNC16 3'h7
`endif

//--- verilog/hrp_pkg.sv
// types shared by the histogram ram processor
`default_nettype none
`include "hrp_cfg.svh"
package hrp_pkg;
    typedef logic [`HRP_DATA_W-1:0] hrp_word_type;
    typedef logic [`HRP_ADDR_W-1:0] hrp_addr_type;
    typedef enum logic [2:0] {
        HRP_MODE_HIST = `HRP_MODE_HIST,
        HRP_MODE_HISTACC = `HRP_MODE_HISTACC,
        HRP_MODE_DELAYSUB = `HRP_MODE_DELAYSUB,
        HRP_MODE_LOOKUP = `HRP_MODE_LOOKUP,
        HRP_MODE_BINACC = `HRP_MODE_BINACC,
        HRP_MODE_DELAYMEM = `HRP_MODE_DELAYMEM,
        HRP_MODE_ASYNC24 = `HRP_MODE_ASYNC24,
        HRP_MODE_ASYNC16 = `HRP_MODE_ASYNC16
    } hrp_mode_type;
    // one item travelling down the gate and sample delay line
    typedef struct packed {
        logic gateLow;
        logic writeOk;
        hrp_word_type sample;
    } hrp_delay_type;
endpackage
`default_nettype wire

//--- verilog/hrp_ram.sv
// 24-bit word memory with registered read and a flash-clearable valid map
`timescale 1ns/100ps
`default_nettype none
`include "hrp_cfg.svh"
module hrp_ram #(
    parameter int WIDTH = `HRP_DATA_W,
    parameter int DEPTH = `HRP_DEPTH,
    parameter int AW = `HRP_ADDR_W
) (
    input wire logic clk,
    input wire logic clearN,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [DEPTH-1:0] wordValid;

    // storage itself, no reset; read-first on a same-edge collision
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // valid map: flash clear makes every word read as zero at once
    always_ff @(posedge clk or negedge clearN) begin
        if (!clearN) begin
            wordValid <= '0;
        end else if (wrEn) begin
            wordValid[wrAddr] <= 1'b1;
        end
    end

    // registered read port, cleared with the output path
    always_ff @(posedge clk or negedge clearN) begin
        if (!clearN) begin
            rdData <= '0;
        end else begin
            rdData <= wordValid[rdAddr] ? mem[rdAddr] : '0;
        end
    end
endmodule // hrp_ram
`default_nettype wire

//--- verilog/hrp_delay_line.sv
// fixed-length delay line for the gate and sample stream
`timescale 1ns/100ps
`default_nettype none
`include "hrp_cfg.svh"
module hrp_delay_line #(
    parameter int WIDTH = 26,
    parameter int DEPTH = `HRP_PIPE_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    logic [DEPTH-1:0][WIDTH-1:0] stage;

    // one register per stage of delay
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : gStage
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stage[i] <= '0;
                end else begin
                    stage[i] <= (i == 0) ? dataIn : stage[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    assign dataOut = stage[DEPTH-1];
endmodule // hrp_delay_line
`default_nettype wire

//--- verilog/hrp_histogram_ram_processor.sv
// top of the histogram ram processor: mode decode, pipeline, counter, data bus
//
// Summary of operation
// - memory of 1024 words, 24 bits each
// - mode_select taken on mode_load_n rising edge
// - pixel index or counter addresses ram
// - counter resets on first edge gate low
// - async addresses taken on strobe falling edges
// - sync output clocked, read strobe enables it
// - async reads and writes go straight through
// - flash clear zeroes ram and output path
// - histogram adds one to addressed bin
// - gate high means lookup read, no writes
// - gate effect delayed three cycles
// - accumulate mode writes running sum sequentially
// - gate low clears sum and counter
// - counter holds at 1023, writes stop
// - last accumulated value stays on bus
// - bin accumulate adds delayed sample data
// - bin accumulate gate high gives lookup read
// - lookup write stores delayed samples, shows old
// - lookup write stops after 1024 words
// - async write data taken on strobe rise
`timescale 1ns/100ps
`default_nettype none
`include "hrp_cfg.svh"
module hrp_histogram_ram_processor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic modeLoadN,
    input wire logic [2:0] modeSelect,
    input wire logic flashClearN,
    input wire logic runGateN,
    input wire hrp_pkg::hrp_addr_type binIndexIn,
    input wire hrp_pkg::hrp_word_type sampleInBus,
    input wire logic hostReadN,
    input wire logic hostWriteN,
    input wire hrp_pkg::hrp_addr_type hostRamAddr,
    input wire hrp_pkg::hrp_word_type bidirDataBusIn,
    output hrp_pkg::hrp_word_type bidirDataBusOut,
    output logic bidirDataBusOe
);
    import hrp_pkg::*;

    // control state, cleared by the system reset only
    typedef struct packed {
        hrp_mode_type mode;
        logic loadQ;
        logic gateQ;
        logic rdQ;
        logic wrQ;
        hrp_addr_type counter;
        logic done;
        hrp_addr_type addrS1;
        hrp_addr_type addrS2;
        hrp_addr_type addrS3;
        hrp_addr_type hostRdAddr;
        hrp_addr_type hostWrAddr;
        logic oe;
    } hrp_ctrl_type;

    // data path state, also cleared by flash clear
    typedef struct packed {
        hrp_word_type acc;
        hrp_word_type out;
        hrp_word_type rdS3;
        logic w1v;
        hrp_addr_type w1a;
        hrp_word_type w1d;
        logic w2v;
        hrp_addr_type w2a;
        hrp_word_type w2d;
    } hrp_data_type;

    hrp_ctrl_type c;
    hrp_ctrl_type next_c;
    hrp_data_type d;
    hrp_data_type next_d;
    hrp_delay_type dlyIn;
    hrp_delay_type dlyOut;
    logic clrN;
    logic isAsync;
    logic gateLow;
    logic gateFall;
    logic loadRise;
    logic readFall;
    logic writeFall;
    logic writeRise;
    logic cntMode;
    logic writeMode;
    logic limitMode;
    hrp_addr_type addr0;
    hrp_word_type fwd;
    hrp_word_type addend;
    hrp_word_type sum;
    logic ramWrEn;
    hrp_addr_type ramRdAddr;
    hrp_addr_type ramWrAddr;
    hrp_word_type ramWrData;
    hrp_word_type ramRdData;

    // data path clear: system reset or flash clear
    assign clrN = reset_n & flashClearN;

    // strobe edges and mode class decode
    always_comb begin
        isAsync = (c.mode == HRP_MODE_ASYNC24) || (c.mode == HRP_MODE_ASYNC16);
        gateLow = !runGateN;
        gateFall = gateLow && c.gateQ;
        loadRise = modeLoadN && !c.loadQ;
        readFall = !hostReadN && c.rdQ;
        writeFall = !hostWriteN && c.wrQ;
        writeRise = hostWriteN && !c.wrQ;
        limitMode = (c.mode == HRP_MODE_HISTACC) || (c.mode == HRP_MODE_LOOKUP);
        // counter drives the address in these modes, pixels otherwise
        cntMode = (gateLow && limitMode) || (c.mode == HRP_MODE_DELAYSUB)
            || (c.mode == HRP_MODE_DELAYMEM);
        // write-capable only while gate low; gate high is lookup read
        writeMode = gateLow && !isAsync && (limitMode || (c.mode == HRP_MODE_HIST)
            || (c.mode == HRP_MODE_BINACC));
    end

    // stage-0 address and write qualifier
    always_comb begin
        addr0 = cntMode ? (gateFall ? `HRP_ADDR_ZERO : c.counter) : binIndexIn;
        dlyIn.gateLow = gateLow;
        dlyIn.writeOk = writeMode && !(limitMode && c.done && !gateFall);
        dlyIn.sample = sampleInBus;
    end

    // gate and sample delayed to line up with the address pipeline
    hrp_delay_line #(
        .WIDTH($bits(hrp_delay_type)),
        .DEPTH(`HRP_PIPE_DEPTH)
    ) uDelay (
        .clk(clk),
        .reset_n(reset_n),
        .dataIn(dlyIn),
        .dataOut(dlyOut)
    );

    // stage 3: forwarded read value and adder
    always_comb begin
        if (d.w1v && (d.w1a == c.addrS3)) begin
            fwd = d.w1d;
        end else if (d.w2v && (d.w2a == c.addrS3)) begin
            fwd = d.w2d;
        end else begin
            fwd = d.rdS3;
        end
        case (c.mode)
            HRP_MODE_HIST: addend = `HRP_HIST_STEP;
            HRP_MODE_BINACC: addend = dlyOut.sample;
            HRP_MODE_HISTACC: addend = d.acc;
            default: addend = `HRP_WORD_ZERO;
        endcase
        sum = fwd + addend;
    end

    // ram port steering: pipeline in sync modes, host strobes in async
    always_comb begin
        if (isAsync) begin
            ramRdAddr = readFall ? hostRamAddr : c.hostRdAddr;
            ramWrEn = writeRise && flashClearN;
            ramWrAddr = c.hostWrAddr;
            ramWrData = bidirDataBusIn;
        end else begin
            ramRdAddr = c.addrS1;
            ramWrEn = dlyOut.writeOk && flashClearN && (c.mode != HRP_MODE_LOOKUP
                || dlyOut.gateLow);
            ramWrAddr = c.addrS3;
            ramWrData = (c.mode == HRP_MODE_LOOKUP) ? dlyOut.sample : sum;
        end
    end

    // the 1024 by 24 array
    hrp_ram #(
        .WIDTH(`HRP_DATA_W),
        .DEPTH(`HRP_DEPTH),
        .AW(`HRP_ADDR_W)
    ) uRam (
        .clk(clk),
        .clearN(clrN),
        .rdAddr(ramRdAddr),
        .rdData(ramRdData),
        .wrEn(ramWrEn),
        .wrAddr(ramWrAddr),
        .wrData(ramWrData)
    );

    // control next state
    always_comb begin
        next_c = c;
        next_c.loadQ = modeLoadN;
        next_c.gateQ = runGateN;
        next_c.rdQ = hostReadN;
        next_c.wrQ = hostWriteN;
        next_c.oe = !hostReadN;
        next_c.addrS1 = addr0;
        next_c.addrS2 = c.addrS1;
        next_c.addrS3 = c.addrS2;
        if (isAsync && readFall) begin
            next_c.hostRdAddr = hostRamAddr;
        end
        if (isAsync && writeFall) begin
            next_c.hostWrAddr = hostRamAddr;
        end
        if (loadRise) begin
            next_c.mode = hrp_mode_type'(modeSelect);
            next_c.done = 1'b0;
        end else if (!isAsync && cntMode && gateFall) begin
            // the gate-fall item already took address zero, so the next item takes one
            next_c.counter = 10'h001;
            next_c.done = 1'b0;
        end else if (!isAsync && cntMode && gateLow) begin
            if (c.counter == `HRP_LAST_ADDR) begin
                next_c.done = 1'b1;
            end else begin
                next_c.counter = c.counter + 10'h001;
            end
        end
    end

    // data path next state
    always_comb begin
        next_d = d;
        next_d.rdS3 = ramRdData;
        next_d.w1v = ramWrEn && !isAsync;
        next_d.w1a = ramWrAddr;
        next_d.w1d = ramWrData;
        next_d.w2v = d.w1v;
        next_d.w2a = d.w1a;
        next_d.w2d = d.w1d;
        if (isAsync) begin
            next_d.out = ramRdData;
        end else if (dlyOut.writeOk && (c.mode != HRP_MODE_LOOKUP)) begin
            next_d.out = sum;
            if (c.mode == HRP_MODE_HISTACC) begin
                next_d.acc = sum;
            end
        end else if ((c.mode == HRP_MODE_HISTACC) && dlyOut.gateLow) begin
            next_d.out = d.out;
        end else begin
            next_d.out = fwd;
        end
        if (!isAsync && (c.mode == HRP_MODE_HISTACC) && gateFall) begin
            next_d.acc = `HRP_WORD_ZERO;
            next_d.out = `HRP_WORD_ZERO;
        end
    end

    // control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c <= '{mode: HRP_MODE_HIST, loadQ: 1'b1, gateQ: 1'b1, rdQ: 1'b1, wrQ: 1'b1,
                counter: `HRP_ADDR_ZERO, done: 1'b0, addrS1: `HRP_ADDR_ZERO,
                addrS2: `HRP_ADDR_ZERO, addrS3: `HRP_ADDR_ZERO,
                hostRdAddr: `HRP_ADDR_ZERO, hostWrAddr: `HRP_ADDR_ZERO, oe: 1'b0};
        end else begin
            c <= next_c;
        end
    end

    // data registers, flash clear acts at once
    always_ff @(posedge clk or negedge clrN) begin
        if (!clrN) begin
            d <= '0;
        end else begin
            d <= next_d;
        end
    end

    assign bidirDataBusOut = d.out;
    assign bidirDataBusOe = c.oe;

    // checks
    AST_MODE_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
        (modeLoadN && !c.loadQ) |=> (c.mode == $past(modeSelect)))
        else $error("mode not taken on load rise");

    AST_CNT_RESET: assert property (@(posedge clk) disable iff (!reset_n)
        (!isAsync && cntMode && gateFall && !loadRise)
        |=> (c.addrS1 == `HRP_ADDR_ZERO) && (c.counter == 10'h001))
        else $error("counter not reset on gate fall");

    AST_FLASH_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        !flashClearN |-> (bidirDataBusOut == `HRP_WORD_ZERO) && !ramWrEn)
        else $error("output path not zero during flash clear");

    AST_OE_FOLLOWS_READ: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 (bidirDataBusOe == !$past(hostReadN)))
        else $error("bus enable does not follow read strobe");

    AST_GATE_DELAY: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n, 3) |-> (dlyOut.gateLow == $past(!runGateN, 3)))
        else $error("gate not delayed three cycles");

    AST_SAMPLE_DELAY: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n, 3) |-> (dlyOut.sample == $past(sampleInBus, 3)))
        else $error("sample not delayed three cycles");

    AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (c.done && limitMode && gateLow && !gateFall && !loadRise)
        |=> (c.counter == `HRP_LAST_ADDR) && c.done)
        else $error("counter left its final value");

    AST_NO_WRITE_GATE_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
        (ramWrEn && !isAsync) |-> dlyOut.gateLow)
        else $error("sync write with gate high");

    AST_ACC_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
        (!isAsync && (c.mode == HRP_MODE_HISTACC) && gateFall && !loadRise && flashClearN)
        |=> (d.acc == `HRP_WORD_ZERO) && (bidirDataBusOut == `HRP_WORD_ZERO))
        else $error("accumulation not cleared");

    AST_ASYNC_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
        (isAsync && writeRise && flashClearN) |-> ramWrEn && (ramWrData == bidirDataBusIn))
        else $error("async write not issued on strobe rise");

    AST_CNT_STEP: assert property (@(posedge clk) disable iff (!reset_n)
        (!isAsync && cntMode && gateLow && !gateFall && !loadRise
        && (c.counter != `HRP_LAST_ADDR)) |=> (c.counter == $past(c.counter) + 10'h001))
        else $error("counter did not step");

    COV_HIST_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
        (c.mode == HRP_MODE_HIST) && ramWrEn);
    COV_ACC_DONE: cover property (@(posedge clk) disable iff (!reset_n)
        (c.mode == HRP_MODE_HISTACC) && c.done);
    COV_LUT_FULL: cover property (@(posedge clk) disable iff (!reset_n)
        (c.mode == HRP_MODE_LOOKUP) && c.done && gateLow);
    COV_ASYNC_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
        isAsync && ramWrEn);
    COV_BIN_WRITE: cover property (@(posedge clk) disable iff (!reset_n)
        (c.mode == HRP_MODE_BINACC) && ramWrEn);
endmodule // hrp_histogram_ram_processor
`default_nettype wire

//--- testbench/hrp_host_model.sv
// host side of the shared data pin: resolves the 24-bit bus level
`timescale 1ns/100ps
`default_nettype none
module hrp_host_model (
    input wire logic clk,
    input wire logic hostDrive,
    input wire hrp_pkg::hrp_word_type hostData,
    input wire logic devOe,
    input wire hrp_pkg::hrp_word_type devOut,
    output hrp_pkg::hrp_word_type busIn
);
    import hrp_pkg::*;
    hrp_word_type lastVal;
    // released bus shows the inverse of the last level, never a stale copy
    always_comb begin
        if (hostDrive) begin
            busIn = hostData;
        end else if (devOe) begin
            busIn = devOut;
        end else begin
            busIn = ~lastVal;
        end
    end
    // remember the level seen on the wire
    always_ff @(posedge clk) begin
        lastVal <= busIn;
    end
endmodule // hrp_host_model
`default_nettype wire

//--- testbench/hrp_histogram_ram_processor_tb_top.sv
// self-checking bench of the histogram ram processor
`timescale 1ns/100ps
`default_nettype none
module hrp_histogram_ram_processor_tb_top;
    import hrp_pkg::*;
    logic clk, reset_n, modeLoadN, flashClearN, runGateN, hostReadN, hostWriteN, hostDrive;
    logic [2:0] modeSelect;
    hrp_addr_type binIndexIn, hostRamAddr;
    hrp_word_type sampleInBus, hostData, busIn, busOut;
    logic busOe;
    int badCount = 0;
    int nCompared = 0;

    hrp_histogram_ram_processor DUT (.clk(clk), .reset_n(reset_n), .modeLoadN(modeLoadN),
        .modeSelect(modeSelect), .flashClearN(flashClearN), .runGateN(runGateN),
        .binIndexIn(binIndexIn), .sampleInBus(sampleInBus), .hostReadN(hostReadN),
        .hostWriteN(hostWriteN), .hostRamAddr(hostRamAddr), .bidirDataBusIn(busIn),
        .bidirDataBusOut(busOut), .bidirDataBusOe(busOe));
    hrp_host_model host (.clk(clk), .hostDrive(hostDrive), .hostData(hostData),
        .devOe(busOe), .devOut(busOut), .busIn(busIn));

    // clock and time-zero values
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input hrp_word_type seen, input hrp_word_type exp);
        nCompared++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // mode load with the gate held high around it
    task automatic loadMode(input hrp_mode_type m);
        @(posedge clk);
        runGateN <= 1'b1;
        modeLoadN <= 1'b0;
        @(posedge clk);
        modeLoadN <= 1'b1;
        modeSelect <= m;
        tick(2);
    endtask

    // host write: address moves away once the falling strobe is seen
    task automatic asyncWrite(input hrp_addr_type a, input hrp_word_type d);
        @(posedge clk);
        hostWriteN <= 1'b0;
        hostRamAddr <= a;
        hostDrive <= 1'b1;
        hostData <= d;
        tick(1);
        hostRamAddr <= ~a;
        tick(1);
        hostWriteN <= 1'b1;
        tick(1);
        hostDrive <= 1'b0;
        hostData <= ~d;
        tick(1);
    endtask

    task automatic asyncRead(input hrp_addr_type a, input hrp_word_type exp);
        @(posedge clk);
        hostReadN <= 1'b0;
        hostRamAddr <= a;
        tick(1);
        hostRamAddr <= ~a;
        tick(2);
        #1;
        check(busOut, exp);
        check({23'h000000, busOe}, 24'h000001);
        @(posedge clk);
        hostReadN <= 1'b1;
        tick(1);
    endtask

    // one sync item per edge
    task automatic item(input logic g, input hrp_addr_type b, input hrp_word_type s);
        @(posedge clk);
        runGateN <= g;
        binIndexIn <= b;
        sampleInBus <= s;
    endtask

    // hold a lookup address and look at the settled output
    task automatic lookRead(input hrp_addr_type b, input hrp_word_type exp);
        item(1'b1, b, 24'h000000);
        tick(6);
        #1;
        check(busOut, exp);
    endtask

    task automatic scenAsync;
        loadMode(HRP_MODE_ASYNC24);
        asyncWrite(10'h000, 24'hA5C3F0);
        asyncWrite(10'h3FF, 24'h5A0F3C);
        asyncWrite(10'h001, 24'hFFFFFF);
        asyncRead(10'h000, 24'hA5C3F0);
        asyncRead(10'h3FF, 24'h5A0F3C);
        asyncRead(10'h001, 24'hFFFFFF);
    endtask

    task automatic scenFlash;
        @(posedge clk);
        flashClearN <= 1'b0;
        hostReadN <= 1'b0;
        tick(2);
        #1;
        check(busOut, 24'h000000);
        @(posedge clk);
        flashClearN <= 1'b1;
        hostReadN <= 1'b1;
        asyncRead(10'h3FF, 24'h000000);
        asyncRead(10'h000, 24'h000000);
    endtask

    task automatic scenHist;
        loadMode(HRP_MODE_HIST);
        hostReadN <= 1'b0;
        tick(1);
        item(1'b0, 10'h007, 24'h000000);
        item(1'b0, 10'h007, 24'h000000);
        item(1'b0, 10'h009, 24'h000000);
        lookRead(10'h007, 24'h000002);
        lookRead(10'h009, 24'h000001);
        check({23'h000000, busOe}, 24'h000001);
        @(posedge clk);
        hostReadN <= 1'b1;
        tick(2);
        #1;
        check({23'h000000, busOe}, 24'h000000);
        @(posedge clk);
        hostReadN <= 1'b0;
    endtask

    task automatic scenBin;
        loadMode(HRP_MODE_BINACC);
        item(1'b0, 10'h005, 24'h000010);
        item(1'b0, 10'h005, 24'h000020);
        item(1'b0, 10'h007, 24'h000003);
        lookRead(10'h005, 24'h000030);
        lookRead(10'h007, 24'h000005);
    endtask

    task automatic scenLut;
        loadMode(HRP_MODE_LOOKUP);
        item(1'b0, 10'h000, 24'h000001);
        tick(11);
        #1;
        check(busOut, 24'h000005);
        tick(1017);
        sampleInBus <= 24'h000002;
        tick(10);
        runGateN <= 1'b1;
        tick(3);
        lookRead(10'h000, 24'h000001);
        lookRead(10'h3FF, 24'h000001);
    endtask

    task automatic scenAcc;
        loadMode(HRP_MODE_HISTACC);
        item(1'b0, 10'h000, 24'h000000);
        tick(1040);
        #1;
        check(busOut, 24'h000400);
        @(posedge clk);
        runGateN <= 1'b1;
        loadMode(HRP_MODE_ASYNC16);
        hostReadN <= 1'b1;
        asyncRead(10'h000, 24'h000001);
        asyncRead(10'h001, 24'h000002);
        asyncRead(10'h3FF, 24'h000400);
    endtask

    // watchdog: a hang counts as a mismatch
    initial begin
        tick(100000);
        badCount++;
        results();
    end

    // reset, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        modeLoadN = 1'b1;
        modeSelect = 3'h0;
        flashClearN = 1'b1;
        runGateN = 1'b1;
        hostReadN = 1'b1;
        hostWriteN = 1'b1;
        hostDrive = 1'b0;
        hostData = 24'h000000;
        binIndexIn = 10'h000;
        sampleInBus = 24'h000000;
        hostRamAddr = 10'h000;
        tick(3);
        reset_n <= 1'b1;
        tick(1);
        scenAsync();
        scenFlash();
        scenHist();
        scenBin();
        scenLut();
        scenAcc();
        results();
    end
endmodule // hrp_histogram_ram_processor_tb_top
`default_nettype wire
